// *** shared/wwd_defs.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH
`define WWD_OFS_PERIOD_CTRL 8'h00
`define WWD_OFS_CLKWIN_CTRL 8'h04
`define WWD_OFS_PS_LOW 8'h08
`define WWD_OFS_PS_HIGH 8'h0C
`define WWD_OFS_TMR_STATUS 8'h10
`define WWD_OFS_IRQ_STATUS 8'h14
`define WWD_OFS_IRQ_CLEAR 8'h18
`define WWD_OFS_IRQ_ENABLE 8'h1C
`define WWD_OFS_CLEAR_CMD 8'h20
`define WWD_CFG_UNLOCK 3'h7
`define WWD_PERIOD_UNLOCK 5'h1F
`define WWD_PERIOD_DEFAULT 5'h0B
`define WWD_PERIOD_MAX 5'h12
`define WWD_WIN_FULL 3'h7
`define WWD_CS_LFOSC 3'h0
`define WWD_CS_MFOSC 3'h1
`define WWD_MODE_SW 2'h1
`define WWD_MODE_AWAKE 2'h2
`define WWD_MODE_ALWAYS 2'h3
`define WWD_CS_MSB 6
`define WWD_CS_LSB 4
`define WWD_WIN_MSB 2
`define WWD_WIN_LSB 0
`define WWD_PER_MSB 5
`define WWD_PER_LSB 1
`define WWD_SWON_BIT 0
`define WWD_RESP_OKAY 2'h0
`define WWD_RESP_SLVERR 2'h2
`define WWD_TMR_MAX 5'h1F
`define WWD_PS_BITS 18
`define WWD_PS_BASE_LOG2 5'h05
`define WWD_EVT_TIMEOUT 0
`define WWD_EVT_VIOLATION 1
`define WWD_EVT_ARMED 2
`define WWD_EVT_W 3
`define WWD_PULSE_NS 1000
`define WWD_CLK_NS 10
`define WWD_PULSE_CYC ((`WWD_PULSE_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS)
`endif

// *** shared/wwd_pkg.sv ***
// Types shared by the watchdog control block
package wwd_pkg;
  typedef struct packed {
    logic [2:0] clkSrc;
    logic [2:0] winSize;
    logic [4:0] period;
    logic [1:0] mode;
  } wwd_cfg_t;
  typedef struct packed {
    logic [4:0] timer;
    logic armed;
    logic [17:0] prescale;
  } wwd_count_t;
  typedef enum logic [2:0] {
    WWD_IDLE = 3'b001,
    WWD_RESP = 3'b010,
    WWD_HOLD = 3'b100
  } wwd_bus_state_t;
endpackage : wwd_pkg

// *** verilog/wwd_tick_gen.sv ***
// Watchdog oscillator tick from the selected internal source
`timescale 1ns/1ns
`include "wwd_defs.svh"
module wwd_tick_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Oscillator ticks
  input wire logic lfOscTick,
  input wire logic mfOscTick,
  input wire logic [2:0] clkSrc,
  // Selected tick
  output logic wdTick
);
  // Reserved codes stop the counter rather than guess a source
  always_comb begin
    case (clkSrc)
      `WWD_CS_LFOSC: wdTick = lfOscTick;
      `WWD_CS_MFOSC: wdTick = mfOscTick;
      default: wdTick = 1'b0;
    endcase
  end
endmodule : wwd_tick_gen

// *** verilog/wwd_window_chk.sv ***
// Window-open decision from the count and the selected period
`timescale 1ns/1ns
`include "wwd_defs.svh"
module wwd_window_chk (
  // Count and selections
  input wire logic [22:0] elapsed,
  input wire logic [4:0] period,
  input wire logic [2:0] winSize,
  // Result
  output logic winOpen,
  output logic expired
);
  logic [4:0] pLog;
  logic [23:0] full;
  logic [26:0] scaled;
  logic [26:0] need;
  // Reserved period codes fall back to the shortest interval
  always_comb begin
    pLog = (period > `WWD_PERIOD_MAX) ? `WWD_PS_BASE_LOG2 : 5'(period + `WWD_PS_BASE_LOG2);
    full = 24'h000001 << pLog;
    scaled = {1'b0, elapsed, 3'h0};
    need = 27'(full) * 27'(`WWD_WIN_FULL - winSize);
    // Open once elapsed/period reaches (7-code)/8
    winOpen = (winSize == `WWD_WIN_FULL) || (scaled >= need);
    expired = ({1'b0, elapsed} >= full - 24'h000001);
  end
endmodule : wwd_window_chk

// *** verilog/wwd_ctrl.sv ***
// Windowed watchdog control, status and AXI4-Lite register slave
//
// How it works
// R01: Clock-source field bits 6-4; 001 mid oscillator, 000 low, rest reserved.
// R02: Window field bits 2-0; 111 full open, each lower code adds 12.5% delay.
// R03: Config clock source 111 resets the clock-source field to 000.
// R04: Window field resets to the configured window-size setting.
// R05: Config clock source not 111 makes the clock-source field read-only.
// R06: Config window size not 111 makes the window field read-only.
// R07: Eighteen-bit prescale count split over low, high and status registers.
// R08: Low register shows prescale bits 7-0, read-only, reset zero.
// R09: High register shows prescale bits 15-8, read-only, reset zero.
// R10: Status bits 1-0 show prescale bits 17-16, reset zero.
// R11: Status bits 7-3 show the five-bit timer value, reset zero.
// R12: Status bit 2 reads one while armed for a clear.
// R13: Software uses the prescale count mainly for debug.
// R14: Bits 7 and 3 of the clock-window register read zero, ignore writes.
// R15: Reading the period register arms the watchdog before a clear.
// R16: A clear outside the open window is a violation; resets when awake, wakes in sleep.
// R17: Any write to either control register clears timer and prescale.
// R18: Window opens when elapsed fraction reaches the selected delay.
// R19: A clear returns the armed bit to zero.
`timescale 1ns/1ns
`include "wwd_defs.svh"
module wwd_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Configuration word
  input wire wwd_pkg::wwd_cfg_t cfgWord,
  // Oscillator ticks and sleep
  input wire logic lfOscTick,
  input wire logic mfOscTick,
  input wire logic sleepMode,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Watchdog outputs
  output logic wdReset,
  output logic wakeUp,
  output logic irq
);
  // Register state
  logic [2:0] clkSrc_r;
  logic [2:0] winSize_r;
  logic [4:0] period_r;
  logic swOn_r;
  logic armed_r;
  logic [22:0] elapsed_r;
  logic [`WWD_EVT_W-1:0] irqStat_r;
  logic [`WWD_EVT_W-1:0] irqEn_r;
  logic initDone_r;
  logic [7:0] pulseCnt_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [31:0] rData_r;
  logic rValid_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic [1:0] rResp_r;
  wwd_pkg::wwd_bus_state_t wrState_r;
  // Decoded strobes
  logic wrFire;
  logic rdFire;
  logic wrCtrl0;
  logic wrCtrl1;
  logic clearCmd;
  logic wdTick;
  logic winOpen;
  logic expired;
  logic wdActive;
  logic violation;
  logic timeout;
  logic validClear;
  logic [`WWD_EVT_W-1:0] evt;

  // Known register offsets
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `WWD_OFS_PERIOD_CTRL, `WWD_OFS_CLKWIN_CTRL, `WWD_OFS_PS_LOW, `WWD_OFS_PS_HIGH,
      `WWD_OFS_TMR_STATUS, `WWD_OFS_IRQ_STATUS, `WWD_OFS_IRQ_CLEAR,
      `WWD_OFS_IRQ_ENABLE, `WWD_OFS_CLEAR_CMD: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Source select and window decision
  wwd_tick_gen uTick (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .lfOscTick(lfOscTick),
    .mfOscTick(mfOscTick),
    .clkSrc(clkSrc_r),
    .wdTick(wdTick)
  );
  wwd_window_chk uWin (
    .elapsed(elapsed_r),
    .period(period_r),
    .winSize(winSize_r),
    .winOpen(winOpen),
    .expired(expired)
  );

  // Write channel capture; address and data may come in either order
  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign wrFire = awHeld_r && wHeld_r && !bValid_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bValid_r <= 1'b0;
      bResp_r <= `WWD_RESP_OKAY;
      wrState_r <= wwd_pkg::WWD_IDLE;
    end else begin
      case (wrState_r)
        wwd_pkg::WWD_IDLE: begin
          if (wrFire) begin
            bValid_r <= 1'b1;
            bResp_r <= is_mapped(awAddr_r) ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
            wrState_r <= wwd_pkg::WWD_RESP;
          end
        end
        wwd_pkg::WWD_RESP: begin
          if (s_axi_bready) begin
            bValid_r <= 1'b0;
            wrState_r <= wwd_pkg::WWD_IDLE;
          end
        end
        default: wrState_r <= wwd_pkg::WWD_IDLE;
      endcase
    end
  end
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // Write strobes; byte lane 0 carries every byte-wide register
  assign wrCtrl0 = wrFire && wStrb_r[0] && awAddr_r == `WWD_OFS_PERIOD_CTRL;
  assign wrCtrl1 = wrFire && wStrb_r[0] && awAddr_r == `WWD_OFS_CLKWIN_CTRL;
  assign clearCmd = wrFire && wStrb_r[0] && awAddr_r == `WWD_OFS_CLEAR_CMD && wData_r[0];

  // Configuration-dependent reset values caught after release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      initDone_r <= 1'b0;
      clkSrc_r <= `WWD_CS_LFOSC;
      winSize_r <= `WWD_WIN_FULL;
      period_r <= `WWD_PERIOD_DEFAULT;
      swOn_r <= 1'b0;
    end else if (!initDone_r) begin
      initDone_r <= 1'b1;
      // R03: low oscillator default
      clkSrc_r <= (cfgWord.clkSrc == `WWD_CFG_UNLOCK) ? `WWD_CS_LFOSC : cfgWord.clkSrc;
      // R04: window from config
      winSize_r <= cfgWord.winSize;
      period_r <= (cfgWord.period == `WWD_PERIOD_UNLOCK) ? `WWD_PERIOD_DEFAULT : cfgWord.period;
    end else begin
      // R05: clock-source write lock
      if (wrCtrl1 && cfgWord.clkSrc == `WWD_CFG_UNLOCK) begin
        // R01: clock-source field bits
        clkSrc_r <= wData_r[`WWD_CS_MSB:`WWD_CS_LSB];
      end
      // R06: window write lock
      if (wrCtrl1 && cfgWord.winSize == `WWD_CFG_UNLOCK) begin
        // R02: window field bits
        winSize_r <= wData_r[`WWD_WIN_MSB:`WWD_WIN_LSB];
      end
      if (wrCtrl0 && cfgWord.period == `WWD_PERIOD_UNLOCK) begin
        period_r <= wData_r[`WWD_PER_MSB:`WWD_PER_LSB];
      end
      if (wrCtrl0) begin
        swOn_r <= wData_r[`WWD_SWON_BIT];
      end
    end
  end

  // Operating mode from the configuration word
  always_comb begin
    case (cfgWord.mode)
      `WWD_MODE_ALWAYS: wdActive = 1'b1;
      `WWD_MODE_AWAKE: wdActive = !sleepMode;
      `WWD_MODE_SW: wdActive = swOn_r;
      default: wdActive = 1'b0;
    endcase
  end

  // R16: early clear or unarmed clear
  assign violation = clearCmd && wdActive && (!winOpen || !armed_r);
  assign validClear = clearCmd && !violation;
  assign timeout = wdActive && wdTick && expired;

  // Counter; cleared by control writes, valid clears, timeout and disable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      elapsed_r <= 23'h000000;
    // R17: control writes clear count
    end else if (wrCtrl0 || wrCtrl1 || validClear || !wdActive || timeout) begin
      elapsed_r <= 23'h000000;
    end else if (wdTick) begin
      // R18: elapsed drives the window
      elapsed_r <= elapsed_r + 23'h000001;
    end
  end

  // Arming by a read of the period register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_r <= 1'b0;
    // R19: clear disarms
    end else if (clearCmd || wrCtrl0 || wrCtrl1) begin
      armed_r <= 1'b0;
    // R15: arming read
    end else if (rdFire && s_axi_araddr == `WWD_OFS_PERIOD_CTRL) begin
      armed_r <= 1'b1;
    end
  end

  // Reset or wake pulse, stretched so a slow reset tree sees it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseCnt_r <= 8'h00;
    end else if ((timeout || violation) && pulseCnt_r == 8'h00) begin
      pulseCnt_r <= 8'(`WWD_PULSE_CYC);
    end else if (pulseCnt_r != 8'h00) begin
      pulseCnt_r <= pulseCnt_r - 8'h01;
    end
  end
  assign wdReset = pulseCnt_r != 8'h00 && !sleepMode;
  assign wakeUp = pulseCnt_r != 8'h00 && sleepMode;

  // Sticky events, set wins over clear
  assign evt[`WWD_EVT_TIMEOUT] = timeout;
  assign evt[`WWD_EVT_VIOLATION] = violation;
  assign evt[`WWD_EVT_ARMED] = rdFire && s_axi_araddr == `WWD_OFS_PERIOD_CTRL;
  genvar gi;
  generate
    for (gi = 0; gi < `WWD_EVT_W; gi++) begin : gEvt
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          irqStat_r[gi] <= 1'b0;
        end else if (evt[gi]) begin
          irqStat_r[gi] <= 1'b1;
        end else if (wrFire && awAddr_r == `WWD_OFS_IRQ_CLEAR && wData_r[gi]) begin
          irqStat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_r <= 3'h0;
    end else if (wrFire && awAddr_r == `WWD_OFS_IRQ_ENABLE) begin
      irqEn_r <= wData_r[`WWD_EVT_W-1:0];
    end
  end
  assign irq = |(irqStat_r & irqEn_r);

  // Read channel; data registered, one cycle after the address
  assign s_axi_arready = !rValid_r;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= `WWD_RESP_OKAY;
    end else if (rdFire) begin
      rValid_r <= 1'b1;
      rResp_r <= is_mapped(s_axi_araddr) ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
      case (s_axi_araddr)
        `WWD_OFS_PERIOD_CTRL: rData_r <= {26'h0, period_r, swOn_r};
        // R14: bits 7 and 3 zero
        `WWD_OFS_CLKWIN_CTRL: rData_r <= {24'h0, 1'b0, clkSrc_r, 1'b0, winSize_r};
        // R07: prescale split; R13: debug view
        // R08: low byte
        `WWD_OFS_PS_LOW: rData_r <= {24'h0, elapsed_r[7:0]};
        // R09: high byte
        `WWD_OFS_PS_HIGH: rData_r <= {24'h0, elapsed_r[15:8]};
        // R10: R11: R12: status packing
        `WWD_OFS_TMR_STATUS: rData_r <= {24'h0, elapsed_r[22:18], armed_r, elapsed_r[17:16]};
        `WWD_OFS_IRQ_STATUS: rData_r <= {29'h0, irqStat_r};
        `WWD_OFS_IRQ_ENABLE: rData_r <= {29'h0, irqEn_r};
        default: rData_r <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Checks
  a_arm_read: assert property (@(posedge ref_clk) disable iff (!arst_n) // R15
    (rdFire && s_axi_araddr == `WWD_OFS_PERIOD_CTRL && !clearCmd && !wrCtrl0 && !wrCtrl1)
    |=> armed_r) else $error("arming read did not arm");
  a_clear_disarm: assert property (@(posedge ref_clk) disable iff (!arst_n) // R19
    clearCmd |=> !armed_r) else $error("clear left armed set");
  a_write_clears: assert property (@(posedge ref_clk) disable iff (!arst_n) // R17
    (wrCtrl0 || wrCtrl1) |=> elapsed_r == 23'h000000) else $error("count not cleared");
  a_violation_rst: assert property (@(posedge ref_clk) disable iff (!arst_n) // R16
    (violation && pulseCnt_r == 8'h00 && !sleepMode && !$past(sleepMode)) ##1 !sleepMode
    |-> wdReset) else $error("violation gave no reset");
  a_cs_lock: assert property (@(posedge ref_clk) disable iff (!arst_n) // R05
    (initDone_r && cfgWord.clkSrc != `WWD_CFG_UNLOCK) |=> $stable(clkSrc_r))
    else $error("locked clock source changed");
  a_win_lock: assert property (@(posedge ref_clk) disable iff (!arst_n) // R06
    (initDone_r && cfgWord.winSize != `WWD_CFG_UNLOCK) |=> $stable(winSize_r))
    else $error("locked window changed");
  a_cs_reset: assert property (@(posedge ref_clk) disable iff (!arst_n) // R03
    (!initDone_r && cfgWord.clkSrc == `WWD_CFG_UNLOCK) |=> clkSrc_r == `WWD_CS_LFOSC)
    else $error("clock source reset wrong");
  a_win_reset: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    !initDone_r |=> winSize_r == $past(cfgWord.winSize)) else $error("window reset wrong");
  a_full_window: assert property (@(posedge ref_clk) disable iff (!arst_n) // R02
    winSize_r == `WWD_WIN_FULL |-> winOpen) else $error("full window not open");
  a_status_read: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
    (rdFire && s_axi_araddr == `WWD_OFS_TMR_STATUS) |=> rData_r[2] == $past(armed_r))
    else $error("status armed bit wrong");
  c_valid_clear: cover property (@(posedge ref_clk) disable iff (!arst_n) validClear);
  c_violation: cover property (@(posedge ref_clk) disable iff (!arst_n) violation);
  c_timeout: cover property (@(posedge ref_clk) disable iff (!arst_n) timeout);
endmodule : wwd_ctrl

// *** testbench/wwd_ctrl_tb_top.sv ***
// Self-checking bench for the watchdog control and status block
`timescale 1ns/1ns
module wwd_ctrl_tb_top;
  logic ref_clk, arst_n, lfOscTick, mfOscTick, sleepMode, useMid;
  wwd_pkg::wwd_cfg_t cfgWord;
  logic [7:0] awAddr, arAddr;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [31:0] wData, rData, rdV, seed;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, resp;
  logic wdReset, wakeUp, irq;
  int n_fail, comparisons, modelCnt;

  wwd_ctrl i_wwd_ctrl (
    .ref_clk(ref_clk), .arst_n(arst_n), .cfgWord(cfgWord),
    .lfOscTick(lfOscTick), .mfOscTick(mfOscTick), .sleepMode(sleepMode),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .wdReset(wdReset), .wakeUp(wakeUp), .irq(irq)
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic hang(input string name);
    n_fail++;
    $display("BAD %s exp done seen timeout", name);
    tally_and_finish();
  endtask : hang

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Write: ready and valid looked at mid-cycle, released after the taking edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aOk, wOk, bOk;
    @(posedge ref_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    repeat (100) begin
      @(negedge ref_clk);
      aOk = awValid && awReady;
      wOk = wValid && wReady;
      bOk = bValid;
      resp = bResp;
      @(posedge ref_clk);
      if (aOk) awValid <= 1'b0;
      if (wOk) wValid <= 1'b0;
      if (bOk) begin
        bReady <= 1'b0;
        return;
      end
    end
    hang("bvalid");
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic aOk, rOk;
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    repeat (100) begin
      @(negedge ref_clk);
      aOk = arValid && arReady;
      rOk = rValid;
      rdV = rData;
      resp = rResp;
      @(posedge ref_clk);
      if (aOk) arValid <= 1'b0;
      if (rOk) begin
        rReady <= 1'b0;
        return;
      end
    end
    hang("rvalid");
  endtask : axr

  // One oscillator tick every second cycle; model counts them
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (useMid) mfOscTick <= 1'b1;
      else lfOscTick <= 1'b1;
      @(posedge ref_clk);
      {lfOscTick, mfOscTick} <= 2'h0;
    end
    modelCnt += n;
  endtask : ticks

  task automatic wait_rst(input logic lvl, input int lim);
    repeat (lim) begin
      @(negedge ref_clk);
      if (wdReset === lvl) return;
    end
    hang("wdReset");
  endtask : wait_rst

  // Reset held two cycles, first request from the third edge after release
  task automatic do_reset(input wwd_pkg::wwd_cfg_t cfg);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    cfgWord <= cfg;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    modelCnt = 0;
  endtask : do_reset

  // Guard against a hang anywhere
  initial begin
    repeat (50000) @(posedge ref_clk);
    hang("run");
  end

  initial begin
    arst_n = 1'b0;
    cfgWord = '{3'h7, 3'h7, 5'h1F, 2'h3};
    {lfOscTick, mfOscTick, sleepMode, useMid} = 4'h0;
    {awAddr, arAddr, wData} = '0;
    wStrb = 4'hF;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    n_fail = 0;
    comparisons = 0;
    seed = 32'h28B7;
    do_reset('{3'h7, 3'h7, 5'h1F, 2'h3});
    // reset values of the unlocked control register and the prescale and status registers
    axr(8'h04);
    chk("clkwin_rst", rdV, 32'h07);
    axr(8'h08);
    chk("ps_low_rst", rdV, 32'h00);
    axr(8'h0C);
    chk("ps_high_rst", rdV, 32'h00);
    axr(8'h10);
    chk("tmr_rst", rdV, 32'h00);
    // random writes, unimplemented bits stay zero
    repeat (6) begin
      seed = xs(seed);
      axw(8'h04, seed);
      axr(8'h04);
      chk("clkwin_rw", rdV, seed & 32'h77);
    end
    axw(8'h04, 32'h00);
    chk("wr_okay", resp, 32'h0);
    // Unmapped place answers with an error
    axw(8'h40, 32'hFF);
    chk("unmap_w", resp, 32'h2);
    axr(8'h40);
    chk("unmap_r", {rdV[29:0], resp}, 32'h2);
    // Shortest period, interrupts masked
    axw(8'h00, 32'h00);
    axw(8'h1C, 32'h00);
    axw(8'h18, 32'h07);
    modelCnt = 0;
    // count visible, cleared by a control write
    ticks(10);
    axr(8'h08);
    chk("ps_low", rdV, modelCnt & 32'hFF);
    axw(8'h04, 32'h00);
    modelCnt = 0;
    axr(8'h08);
    chk("ps_clr", rdV, 32'h00);
    ticks(10);
    axr(8'h00);
    axr(8'h10);
    chk("armed", rdV, 32'h04);
    axw(8'h20, 32'h01);
    wait_rst(1'b1, 20);
    chk("irq_mask", irq, 1'b0);
    chk("wake_awake", wakeUp, 1'b0);
    axw(8'h1C, 32'h02);
    chk("irq_on", irq, 1'b1);
    axr(8'h14);
    chk("viol_flag", rdV & 32'h2, 32'h2);
    wait_rst(1'b0, 300);
    axw(8'h18, 32'h07);
    chk("irq_off", irq, 1'b0);
    axr(8'h14);
    chk("flag_clr", rdV & 32'h7, 32'h0);
    // armed clear inside the open window
    axw(8'h04, 32'h00);
    modelCnt = 0;
    ticks(29);
    axr(8'h00);
    axw(8'h20, 32'h01);
    repeat (10) begin
      @(negedge ref_clk);
      chk("no_reset", wdReset, 1'b0);
    end
    axr(8'h10);
    chk("disarmed", rdV, 32'h00);
    axr(8'h08);
    chk("clr_cnt", rdV, 32'h00);
    axw(8'h04, 32'h07);
    axw(8'h20, 32'h01);
    wait_rst(1'b1, 20);
    wait_rst(1'b0, 300);
    // Timeout at 32 ticks
    axw(8'h04, 32'h00);
    axw(8'h18, 32'h07);
    ticks(31);
    chk("early_to", wdReset, 1'b0);
    ticks(2);
    wait_rst(1'b1, 20);
    axr(8'h14);
    chk("to_flag", rdV & 32'h1, 32'h1);
    wait_rst(1'b0, 300);
    // mid source counts, low ticks ignored while it is selected
    do_reset('{3'h7, 3'h7, 5'h1F, 2'h2});
    axw(8'h04, 32'h17);
    axw(8'h00, 32'h00);
    modelCnt = 0;
    useMid = 1'b1;
    ticks(5);
    useMid = 1'b0;
    ticks(3);
    axr(8'h08);
    chk("mid_src", rdV, modelCnt - 3);
    // Awake-only mode stops and clears the count in sleep
    sleepMode <= 1'b1;
    useMid = 1'b1;
    ticks(4);
    axr(8'h08);
    chk("sleep_off", rdV, 32'h00);
    // Timeout in sleep wakes the core instead of resetting it
    do_reset('{3'h7, 3'h7, 5'h1F, 2'h3});
    axw(8'h04, 32'h17);
    axw(8'h00, 32'h00);
    ticks(32);
    @(negedge ref_clk);
    chk("wake", wakeUp, 1'b1);
    chk("no_rst_sleep", wdReset, 1'b0);
    repeat (110) @(posedge ref_clk);
    chk("wake_end", wakeUp, 1'b0);
    sleepMode <= 1'b0;
    // Software-enable mode follows the enable bit
    do_reset('{3'h7, 3'h7, 5'h1F, 2'h1});
    useMid = 1'b0;
    axw(8'h00, 32'h01);
    modelCnt = 0;
    ticks(4);
    axr(8'h08);
    chk("sw_on", rdV, modelCnt);
    axw(8'h00, 32'h00);
    ticks(4);
    axr(8'h08);
    chk("sw_off", rdV, 32'h00);
    do_reset('{3'h0, 3'h3, 5'h04, 2'h3});
    axr(8'h04);
    chk("win_cfg", rdV, 32'h03);
    axw(8'h04, 32'h77);
    axr(8'h04);
    chk("locked", rdV, 32'h03);
    tally_and_finish();
  end
endmodule : wwd_ctrl_tb_top
